/* rtl/fwsr_pkg.sv */
package fwsr_pkg;
   // ----------------------------------------------------------------------
   // bus timing
   // ----------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS   = 5000;
   localparam int unsigned STATUS_DELAY_NS = 4000;  // status settle, 4 us
   localparam int unsigned STATUS_DELAY_CYC =
      (STATUS_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned ACCESS_NS       = 110;
   localparam int unsigned ACCESS_CYC      =
      (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned STROBE_NS       = 50;
   localparam int unsigned STROBE_CYC      =
      (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned CNT_W           = 16;

   localparam int unsigned DATA_W          = 16;
   localparam int unsigned ADDR_W          = 24;

   // ----------------------------------------------------------------------
   // status bit positions
   // ----------------------------------------------------------------------
   localparam int unsigned POLL_POS        = 7;
   localparam int unsigned TOGGLE1_POS     = 6;
   localparam int unsigned TIMEOUT_POS     = 5;
   localparam int unsigned TOGGLE2_POS     = 2;

   localparam logic [15:0] RESET_CMD_DATA  = 16'h00f0;

   // ----------------------------------------------------------------------
   // result codes
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      FWSR_RES_OK      = 2'h0,
      FWSR_RES_FAIL    = 2'h1,
      FWSR_RES_NONE    = 2'h2
   } fwsr_result_t;

   typedef enum logic [2:0] {
      FWSR_IDLE    = 3'h0,
      FWSR_SETTLE  = 3'h1,
      FWSR_READ_A  = 3'h3,
      FWSR_READ_B  = 3'h2,
      FWSR_CHECK   = 3'h6,
      FWSR_RECHECK = 3'h7,
      FWSR_RESETC  = 3'h5,
      FWSR_DONE    = 3'h4
   } fwsr_state_t;
endpackage : fwsr_pkg

/* rtl/fwsr_bus_cycle.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// one asynchronous read or write cycle on the flash pins
// ---------------------------------------------------------------------------
module fwsr_bus_cycle
   import fwsr_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              start,
   input  wire logic              is_write,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic [DATA_W-1:0] dq_sync,
   output logic                   done,
   output logic [DATA_W-1:0]      rdata,
   output logic                   chip_select_n,
   output logic                   output_strobe_n,
   output logic                   write_strobe_n,
   output logic [DATA_W-1:0]      dq_out,
   output logic                   dq_oe_n
);
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic             busy;
   logic             next_busy;
   logic             wr;
   logic             next_wr;
   logic             pend;
   logic             next_pend;
   logic             go_wr;
   logic [DATA_W-1:0] next_rdata;
   logic [DATA_W-1:0] next_dq_out;

   // reads wait access time, two synchroniser stages and a capture cycle
   localparam logic [CNT_W-1:0] RD_LEN = CNT_W'(ACCESS_CYC + 3);
   localparam logic [CNT_W-1:0] WR_LEN = CNT_W'(STROBE_CYC);

   always_comb begin
      next_cnt    = cnt;
      next_busy   = busy;
      next_wr     = wr;
      next_pend   = pend;
      next_rdata  = rdata;
      next_dq_out = dq_out;
      done        = 1'b0;
      go_wr       = pend ? wr : is_write;
      if (!busy) begin
         if (start || pend) begin
            next_busy   = 1'b1;
            next_pend   = 1'b0;
            next_wr     = go_wr;
            next_dq_out = wdata;
            next_cnt    = go_wr ? WR_LEN : RD_LEN;
         end
      end else if (cnt != '0) begin
         next_cnt = cnt - CNT_W'(1);
         // sample before done, so the caller sees this read's data
         if (!wr && cnt == CNT_W'(1))
            next_rdata = dq_sync;
      end else begin
         // a start in the closing cycle waits one idle cycle
         next_busy = 1'b0;
         next_pend = start;
         next_wr   = is_write;
         done      = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt    <= '0;
         busy   <= 1'b0;
         wr     <= 1'b0;
         pend   <= 1'b0;
         rdata  <= '0;
         dq_out <= '0;
      end else begin
         cnt    <= next_cnt;
         busy   <= next_busy;
         wr     <= next_wr;
         pend   <= next_pend;
         rdata  <= next_rdata;
         dq_out <= next_dq_out;
      end
   end

   // strobes rise at cycle end, so each read is a fresh framed cycle
   assign chip_select_n   = ~busy;
   assign output_strobe_n = ~(busy & ~wr);
   assign write_strobe_n  = ~(busy & wr & (cnt != '0));
   assign dq_oe_n         = ~(busy & wr);
endmodule : fwsr_bus_cycle

/* rtl/fwsr_poll_ctrl.sv */
`timescale 1ns/100ps
// Functional notes
// - status trusted only 4 us after command
// - present program address when polling
// - poll at address in erased sector
// - final data needs one more read
// - two reads, compare toggle, equal means done
// - toggling with timeout: recheck, then reset
// - resumed monitoring restarts whole sequence
// - reread polling bit after timeout seen
module fwsr_poll_ctrl
   import fwsr_pkg::*;
#(
   parameter int unsigned SETTLE_CYC = STATUS_DELAY_CYC
)(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              cmd_start,
   input  wire logic              cmd_use_poll,
   input  wire logic [DATA_W-1:0] cmd_expect,
   input  wire logic [ADDR_W-1:0] cmd_addr,
   output logic                   cmd_ready,
   output logic                   res_valid,
   output fwsr_result_t           res_code,
   output logic [DATA_W-1:0]      res_data,
   output logic                   dev_busy,
   output logic [ADDR_W-1:0]      addr_out,
   output logic                   chip_select_n,
   output logic                   output_strobe_n,
   output logic                   write_strobe_n,
   output logic [DATA_W-1:0]      dq_out,
   output logic                   dq_oe_n,
   input  wire logic [DATA_W-1:0] dq_in,
   input  wire logic              ready_busy_in
);
   // -----------------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------------
   logic [DATA_W-1:0] dq_meta;
   logic [DATA_W-1:0] dq_sync;
   logic              rb_meta;
   logic              rb_sync;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dq_meta <= '0;
         dq_sync <= '0;
         rb_meta <= 1'b1;
         rb_sync <= 1'b1;
      end else begin
         dq_meta <= dq_in;
         dq_sync <= dq_meta;
         rb_meta <= ready_busy_in;
         rb_sync <= rb_meta;
      end
   end

   // open drain line is read only; low means busy
   assign dev_busy = ~rb_sync;

   // -----------------------------------------------------------------------
   // sequencer
   // -----------------------------------------------------------------------
   fwsr_state_t       state;
   fwsr_state_t       next_state;
   logic [CNT_W-1:0]  cnt;
   logic [CNT_W-1:0]  next_cnt;
   logic [DATA_W-1:0] first;
   logic [DATA_W-1:0] next_first;
   logic              poll;
   logic              next_poll;
   logic [DATA_W-1:0] expect_q;
   logic [DATA_W-1:0] next_expect_q;
   logic [ADDR_W-1:0] next_addr_out;
   logic              next_res_valid;
   fwsr_result_t      next_res_code;
   logic [DATA_W-1:0] next_res_data;
   logic              bc_start;
   logic              bc_write;
   logic              bc_done;
   logic [DATA_W-1:0] bc_rdata;
   logic              timed_out;
   logic              poll_match;
   logic              toggling;

   // timeout flag set means the embedded operation gave up
   assign timed_out  = bc_rdata[TIMEOUT_POS];
   // true written bit reappears on completion
   assign poll_match = bc_rdata[POLL_POS] == expect_q[POLL_POS];
   // any change of either toggle bit between two reads
   assign toggling   = (bc_rdata[TOGGLE1_POS] != first[TOGGLE1_POS]) |
                       (bc_rdata[TOGGLE2_POS] != first[TOGGLE2_POS]);
   assign cmd_ready  = (state == FWSR_IDLE);

   always_comb begin
      next_state     = state;
      next_cnt       = cnt;
      next_first     = first;
      next_poll      = poll;
      next_expect_q  = expect_q;
      next_addr_out  = addr_out;
      next_res_valid = 1'b0;
      next_res_code  = res_code;
      next_res_data  = res_data;
      bc_start       = 1'b0;
      bc_write       = 1'b0;
      case (state)
         FWSR_IDLE: begin
            // every new request starts from the top
            if (cmd_start) begin
               next_poll     = cmd_use_poll;
               next_expect_q = cmd_expect;
               next_addr_out = cmd_addr;  // program or erase sector
               next_cnt      = CNT_W'(SETTLE_CYC);
               next_state    = FWSR_SETTLE;
            end
         end
         FWSR_SETTLE: begin
            // no status trusted before settle time
            if (cnt != '0)
               next_cnt = cnt - CNT_W'(1);
            else begin
               bc_start   = 1'b1;
               next_state = FWSR_READ_A;
            end
         end
         FWSR_READ_A: begin
            if (bc_done) begin
               next_first = bc_rdata;
               if (poll) begin
                  // polling: match ends, timeout forces a reread
                  if (poll_match)
                     next_state = FWSR_DONE;
                  else if (timed_out)
                     next_state = FWSR_RECHECK;
                  else
                     next_state = FWSR_READ_A;
                  bc_start = !poll_match;
               end else begin
                  bc_start   = 1'b1;
                  next_state = FWSR_READ_B;  // back-to-back pair
               end
            end
         end
         FWSR_READ_B: begin
            if (bc_done) begin
               if (!toggling)
                  next_state = FWSR_DONE;  // stopped: finished
               else if (timed_out) begin
                  bc_start   = 1'b1;
                  next_first = bc_rdata;
                  next_state = FWSR_CHECK;  // toggle may stop with flag
               end else begin
                  bc_start   = 1'b1;
                  next_first = bc_rdata;
               end
            end
         end
         FWSR_CHECK: begin
            if (bc_done) begin
               if (!toggling)
                  next_state = FWSR_DONE;
               else begin
                  bc_start   = 1'b1;
                  bc_write   = 1'b1;
                  next_state = FWSR_RESETC;  // failed: reset command
               end
            end
         end
         FWSR_RECHECK: begin
            if (bc_done) begin
               if (poll_match)
                  next_state = FWSR_DONE;
               else begin
                  bc_start   = 1'b1;
                  bc_write   = 1'b1;
                  next_state = FWSR_RESETC;
               end
            end
         end
         FWSR_RESETC: begin
            if (bc_done) begin
               next_res_valid = 1'b1;
               next_res_code  = FWSR_RES_FAIL;
               next_res_data  = bc_rdata;
               next_state     = FWSR_IDLE;
            end
         end
         FWSR_DONE: begin
            // one more read for fully valid array data
            if (!bc_start)
               bc_start = 1'b1;
            next_state = FWSR_RESETC;
            next_res_code = FWSR_RES_NONE;
         end
         default: next_state = FWSR_IDLE;
      endcase
      // final array read reports success
      if (state == FWSR_RESETC && res_code == FWSR_RES_NONE && bc_done)
         next_res_code = FWSR_RES_OK;
      if (state == FWSR_RESETC && res_code == FWSR_RES_NONE && bc_done)
         next_res_data = bc_rdata;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state     <= FWSR_IDLE;
         cnt       <= '0;
         first     <= '0;
         poll      <= 1'b0;
         expect_q  <= '0;
         addr_out  <= '0;
         res_valid <= 1'b0;
         res_code  <= FWSR_RES_NONE;
         res_data  <= '0;
      end else begin
         state     <= next_state;
         cnt       <= next_cnt;
         first     <= next_first;
         poll      <= next_poll;
         expect_q  <= next_expect_q;
         addr_out  <= next_addr_out;
         res_valid <= next_res_valid;
         res_code  <= next_res_code;
         res_data  <= next_res_data;
      end
   end

   fwsr_bus_cycle u_cycle (
      .clk             (clk),
      .sys_rst         (sys_rst),
      .start           (bc_start),
      .is_write        (bc_write),
      .wdata           (RESET_CMD_DATA),
      .dq_sync         (dq_sync),
      .done            (bc_done),
      .rdata           (bc_rdata),
      .chip_select_n   (chip_select_n),
      .output_strobe_n (output_strobe_n),
      .write_strobe_n  (write_strobe_n),
      .dq_out          (dq_out),
      .dq_oe_n         (dq_oe_n)
   );
endmodule : fwsr_poll_ctrl

/* tb/fwsr_poll_monitor.sv */
`timescale 1ns/100ps
module fwsr_poll_monitor
   import fwsr_pkg::*;
#(
   parameter int unsigned SETTLE_CYC = STATUS_DELAY_CYC
)(
   input wire logic              clk,
   input wire logic              sys_rst,
   input wire logic              cmd_start,
   input wire logic              cmd_ready,
   input wire logic              res_valid,
   input wire fwsr_result_t      res_code,
   input wire logic              dev_busy,
   input wire logic              chip_select_n,
   input wire logic              output_strobe_n,
   input wire logic              write_strobe_n,
   input wire logic [DATA_W-1:0] dq_out,
   input wire logic              dq_oe_n,
   input wire logic              ready_busy_in
);
   // ---------------------------------------------------------------
   // settle window after a command is taken
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] gap;
   logic [CNT_W-1:0] next_gap;
   always_comb begin
      next_gap = '0;
      if (cmd_start && cmd_ready) begin
         next_gap = 16'h0001;
      end else if (gap != '0 && gap < CNT_W'(SETTLE_CYC)) begin
         next_gap = gap + 16'h0001;
      end
   end
   always_ff @(posedge clk) begin
      gap <= sys_rst ? '0 : next_gap;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence read_hold;
      !output_strobe_n [*8];
   endsequence
   sequence fail_answer;
      ##[1:200] (res_valid && res_code == FWSR_RES_FAIL);
   endsequence
   settle_quiet_a: assert property (
      gap != '0 |-> output_strobe_n && chip_select_n)
      else $error("read started inside settle wait");
   read_hold_a: assert property (
      $fell(output_strobe_n) |-> read_hold)
      else $error("read strobe released too early");
   read_framed_a: assert property (
      !output_strobe_n |-> !chip_select_n && dq_oe_n && write_strobe_n)
      else $error("read strobe outside a clean read");
   reset_write_a: assert property (
      !write_strobe_n |-> !dq_oe_n && !chip_select_n
                          && dq_out == RESET_CMD_DATA)
      else $error("write other than the reset command");
   fail_after_a: assert property (
      $rose(write_strobe_n) |-> fail_answer)
      else $error("no failure result after reset write");
   result_pulse_a: assert property (
      res_valid |=> !res_valid)
      else $error("result pulse longer than one cycle");
   busy_sync_a: assert property (
      !ready_busy_in [*3] |-> dev_busy)
      else $error("busy line low but not flagged");
   ready_sync_a: assert property (
      ready_busy_in [*3] |-> !dev_busy)
      else $error("busy line released but still flagged");
endmodule : fwsr_poll_monitor

/* tb/fwsr_flash_model.sv */
`timescale 1ns/100ps
module fwsr_flash_model
   import fwsr_pkg::*;
(
   input  wire logic              chip_select_n,
   input  wire logic              output_strobe_n,
   input  wire logic              write_strobe_n,
   input  wire logic [DATA_W-1:0] dq_out,
   input  wire logic              dq_oe_n,
   output logic [DATA_W-1:0]      dq_in,
   output logic                   rb_oe_n
);
   // ---------------------------------------------------------------
   // status answers of a busy device
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] arr;
   logic [DATA_W-1:0] stat;
   logic              erasing;
   logic              stuck;
   logic              got_reset;
   int                busy_left;
   initial begin
      dq_in = 16'h0000;
      busy_left = 0;
      got_reset = 1'b0;
   end
   // short counts stand for protected-target activity
   task automatic start_op(input logic erase, input logic [DATA_W-1:0] data,
                           input int reads, input logic fail);
      arr = data;
      erasing = erase;
      stuck = fail;
      stat = '0;
      stat[TIMEOUT_POS] = fail;
      got_reset = 1'b0;
      busy_left = reads;
   endtask : start_op
   assign rb_oe_n = (busy_left == 0);
   always @(negedge output_strobe_n) begin
      // both strobes fall in one step; let them settle first
      #1;
      if (!chip_select_n && busy_left > 0) begin
         stat[TOGGLE1_POS] = ~stat[TOGGLE1_POS];
         stat[TOGGLE2_POS] = stat[TOGGLE2_POS] ^ erasing;
         stat[POLL_POS] = erasing ? 1'b0 : ~arr[POLL_POS];
         dq_in = stat;
         if (!stuck) begin
            busy_left = busy_left - 1;
         end
      end else begin
         dq_in = arr;
      end
   end
   // released bus shows the inverse so a stale sample never matches
   always @(posedge output_strobe_n) begin
      dq_in = ~dq_in;
   end
   always @(posedge write_strobe_n) begin
      if (!dq_oe_n && dq_out == RESET_CMD_DATA) begin
         busy_left = 0;
         got_reset = 1'b1;
      end
   end
endmodule : fwsr_flash_model

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   import fwsr_pkg::*;
   logic              clk;
   logic              sys_rst;
   logic              cmd_start;
   logic              cmd_use_poll;
   logic [DATA_W-1:0] cmd_expect;
   logic [ADDR_W-1:0] cmd_addr;
   logic              cmd_ready;
   logic              res_valid;
   fwsr_result_t      res_code;
   logic [DATA_W-1:0] res_data;
   logic [ADDR_W-1:0] addr_out;
   logic              dev_busy;
   logic              chip_select_n;
   logic              output_strobe_n;
   logic              write_strobe_n;
   logic [DATA_W-1:0] dq_out;
   logic              dq_oe_n;
   logic [DATA_W-1:0] dq_in;
   logic              rb_oe_n;
   logic              ready_busy_in;
   logic              busy_seen;
   int                bad_count;
   int                n_checks;
   // pull-up holds the shared line high when released
   assign ready_busy_in = rb_oe_n ? 1'b1 : 1'b0;
   fwsr_poll_ctrl #(.SETTLE_CYC(4)) dut (
      .clk(clk), .sys_rst(sys_rst), .cmd_start(cmd_start),
      .cmd_use_poll(cmd_use_poll), .cmd_expect(cmd_expect),
      .cmd_addr(cmd_addr), .cmd_ready(cmd_ready), .res_valid(res_valid),
      .res_code(res_code), .res_data(res_data), .dev_busy(dev_busy),
      .addr_out(addr_out), .chip_select_n(chip_select_n),
      .output_strobe_n(output_strobe_n), .write_strobe_n(write_strobe_n),
      .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in),
      .ready_busy_in(ready_busy_in));
   fwsr_flash_model flash (
      .chip_select_n(chip_select_n), .output_strobe_n(output_strobe_n),
      .write_strobe_n(write_strobe_n), .dq_out(dq_out),
      .dq_oe_n(dq_oe_n), .dq_in(dq_in), .rb_oe_n(rb_oe_n));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ---------------------------------------------------------------
   // checking and command tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [DATA_W-1:0] seen,
                        input logic [DATA_W-1:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic run_cmd(input logic poll, input logic [DATA_W-1:0] exp);
      int n;
      n = 0;
      busy_seen = 1'b0;
      @(posedge clk);
      cmd_start    <= 1'b1;
      cmd_use_poll <= poll;
      cmd_expect   <= exp;
      @(posedge clk);
      cmd_start <= 1'b0;
      while (res_valid !== 1'b1 && n < 20000) begin
         @(negedge clk);
         busy_seen = busy_seen | (dev_busy === 1'b1);
         n++;
      end
      if (n >= 20000) begin
         bad_count++;
         report_and_stop();
      end
   endtask : run_cmd
   task automatic do_test(input logic poll, input logic erase, input int reads,
                          input logic fail, input logic [DATA_W-1:0] data);
      flash.start_op(erase, data, reads, fail);
      run_cmd(poll, erase ? 16'h0080 : data);
      check(16'(res_code), fail ? 16'h0001 : 16'h0000, "code");
      check(fail ? 16'(res_data[TIMEOUT_POS]) : res_data,
            fail ? 16'h0001 : data, "array data");
      check(16'(addr_out == cmd_addr), 16'h0001, "address");
      check(16'(flash.got_reset), 16'(fail), "reset write");
      check(16'(busy_seen), 16'h0001, "busy seen");
      $display("test done poll=%0d erase=%0d fail=%0d", poll, erase, fail);
   endtask : do_test
   initial begin
      sys_rst = 1'b1;
      cmd_start = 1'b0;
      cmd_use_poll = 1'b0;
      cmd_expect = 16'h0000;
      cmd_addr = 24'h000100;
      busy_seen = 1'b0;
      bad_count = 0;
      n_checks = 0;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      @(negedge clk);
      check(16'({cmd_ready, output_strobe_n, write_strobe_n, dq_oe_n}),
            16'h000f, "idle pins");
      do_test(1'b0, 1'b0, 3, 1'b0, 16'h1204);
      do_test(1'b1, 1'b0, 3, 1'b0, 16'h00c3);
      do_test(1'b1, 1'b1, 4, 1'b0, 16'hffff);
      do_test(1'b0, 1'b1, 2, 1'b0, 16'hffff);
      do_test(1'b0, 1'b0, 1, 1'b0, 16'h1204);
      do_test(1'b0, 1'b0, 1, 1'b1, 16'h1204);
      do_test(1'b1, 1'b0, 1, 1'b1, 16'h00c3);
      report_and_stop();
   end
endmodule : tb_top
bind fwsr_poll_ctrl fwsr_poll_monitor #(.SETTLE_CYC(SETTLE_CYC)) mon (
   .clk(clk), .sys_rst(sys_rst), .cmd_start(cmd_start),
   .cmd_ready(cmd_ready), .res_valid(res_valid), .res_code(res_code),
   .dev_busy(dev_busy), .chip_select_n(chip_select_n),
   .output_strobe_n(output_strobe_n), .write_strobe_n(write_strobe_n),
   .dq_out(dq_out), .dq_oe_n(dq_oe_n), .ready_busy_in(ready_busy_in));
